// ===== i2c_collision_consts.svh
/*
 * constants for the two-wire master condition block: register byte
 * offsets, field positions, reset values and baud counter timing.
 * assumes it is included by bare name wherever a constant is needed.
 */
`ifndef I2C_COLLISION_CONSTS_SVH
`define I2C_COLLISION_CONSTS_SVH

// register byte offsets, one aligned word each
`define OFS_BAUD_RELOAD    8'h00
`define OFS_SHIFT_BUFFER   8'h04
`define OFS_CONTROL_ONE    8'h08
`define OFS_CONTROL_TWO    8'h0C
`define OFS_CONTROL_THREE  8'h10
`define OFS_ADDRESS_MASK   8'h14
`define OFS_PORT_STATUS    8'h18
`define OFS_COLLISION      8'h1C

// port_control_one fields
`define BIT_PORT_ENABLE    5
`define BIT_SPI_MODE       0
// port_control_two fields
`define BIT_START_REQ      0
`define BIT_RESTART_REQ    1
`define BIT_STOP_REQ       2
// port_status fields
`define BIT_STOP_SEEN      4
`define BIT_START_SEEN     3
`define BIT_SHIFT_BUSY     0
// collision register fields
`define BIT_COLLISION      0
`define BIT_COLL_IRQ_EN    1
`define BIT_EVENT_FLAG     2

// reset values
`define RST_BYTE           8'h00
`define RST_BAUD_RELOAD    8'h13

// baud counter steps once per two oscillator cycles: half period = 2*(reload+1)
`define BAUD_PRESCALE      2
// half periods of one byte on the serial clock
`define SHIFT_HALVES       5'h10

`endif

// ===== i2c_collision_pkg.sv
/*
 * types shared by the condition block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package i2c_collision_pkg;

	// one-hot sequencer states
	typedef enum logic [12:0] {
		ST_IDLE        = 13'h0001,
		ST_START_WAIT  = 13'h0002,
		ST_START_HOLD  = 13'h0004,
		ST_RS_FLOAT    = 13'h0008,
		ST_RS_COUNT    = 13'h0010,
		ST_RS_CLKHI    = 13'h0020,
		ST_RS_CHECK    = 13'h0040,
		ST_RS_HOLD     = 13'h0080,
		ST_STOP_LOW    = 13'h0100,
		ST_STOP_CLKHI  = 13'h0200,
		ST_STOP_COUNT  = 13'h0400,
		ST_STOP_CHECK  = 13'h0800,
		ST_SHIFT       = 13'h1000
	} cond_state_t;

	typedef logic [7:0] byte_t;

endpackage

// ===== baud_counter.sv
/*
 * shared baud counter: a prescaler on the oscillator clock and a down
 * counter that reloads from the software reload value.
 * assumes an active-low reset that asserts at once and is released in step with clk_in.
 */
`timescale 1ns/1ps
`include "i2c_collision_consts.svh"

module baud_counter #(
	parameter int PRESCALE = `BAUD_PRESCALE
) (
	input  wire logic                     clk_in,
	input  wire logic                     rst_n_in,
	input  wire i2c_collision_pkg::byte_t reload_in,
	input  wire logic                     load_in,
	input  wire logic                     run_in,
	output logic                          expire_out
);

	logic [3:0]                 pre;
	i2c_collision_pkg::byte_t   count;
	logic                       tick;

	assign tick = (pre == 4'(PRESCALE - 1));

	// prescaler restarts with every load so a period is exact from the load
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pre <= 4'h0;
		end else if (load_in || !run_in || tick) begin
			pre <= 4'h0;
		end else begin
			pre <= pre + 4'h1;
		end
	end

	// down counter, reloads itself at zero so it runs twice per serial period
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count      <= `RST_BYTE;
			expire_out <= 1'b0;
		end else begin
			expire_out <= 1'b0;
			if (load_in) begin
				count <= reload_in;
			end else if (run_in && tick) begin
				if (count == `RST_BYTE) begin
					count      <= reload_in;
					expire_out <= 1'b1;
				end else begin
					count <= count - 8'h01;
				end
			end
		end
	end

endmodule

// ===== i2c_master_collision_brg.sv
/*
 * two-wire master condition sequencer with bus collision detection for
 * start, repeated start and stop, a byte clocking sequence on the shared
 * baud counter, and an APB register slave.
 * assumes open-drain pins resolved outside; inputs synchronous to clk_in.
 */
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "i2c_collision_consts.svh"

module i2c_master_collision_brg (
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n_out,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe_n_out,
	output logic             collision_irq_out
);

	logic                           rst_sync;
	logic                           rst_n;
	i2c_collision_pkg::cond_state_t state;
	i2c_collision_pkg::cond_state_t next_state;
	i2c_collision_pkg::byte_t       baud_reload_value;
	i2c_collision_pkg::byte_t       serial_shift_buffer;
	i2c_collision_pkg::byte_t       port_control_one;
	i2c_collision_pkg::byte_t       port_control_two;
	i2c_collision_pkg::byte_t       port_control_three;
	i2c_collision_pkg::byte_t       address_mask;
	logic                           collision_flag;
	logic                           collision_irq_enable;
	logic                           port_event_flag;
	logic                           start_seen;
	logic                           stop_seen;
	logic                           sda_oe_n;
	logic                           scl_oe_n;
	logic                           next_sda_oe_n;
	logic                           next_scl_oe_n;
	logic [4:0]                     halves;
	logic                           baud_load;
	logic                           baud_run;
	logic                           baud_expire;
	logic                           set_coll;
	logic                           done;
	logic                           apb_done;
	logic                           wr;
	logic                           buf_write;

	// two-stage release of the asynchronous reset
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_sync <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_sync <= 1'b1;
			rst_n    <= rst_sync;
		end
	end

	function automatic logic addr_valid(input logic [7:0] a);
		addr_valid = (a[1:0] == 2'b00) && (a <= `OFS_COLLISION);
	endfunction

	function automatic logic coll_clear(input logic [31:0] d, input int bitpos);
		coll_clear = d[bitpos];
	endfunction

	// one wait state: pready rises on the second access cycle
	assign apb_done  = psel_in && penable_in && pready_out;
	assign wr        = apb_done && pwrite_in && addr_valid(paddr_in);
	assign buf_write = wr && (paddr_in == `OFS_SHIFT_BUFFER) && state == i2c_collision_pkg::ST_IDLE;

	// APB handshake, read data and error answer registered together
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0000_0000;
		end else begin
			pready_out  <= psel_in && penable_in && !pready_out;
			pslverr_out <= psel_in && penable_in && !pready_out && !addr_valid(paddr_in);
			prdata_out  <= 32'h0000_0000;
			if (psel_in && penable_in && !pready_out && !pwrite_in) begin
				unique case (paddr_in)
					`OFS_BAUD_RELOAD:   prdata_out[7:0] <= baud_reload_value;
					`OFS_SHIFT_BUFFER:  prdata_out[7:0] <= serial_shift_buffer;
					`OFS_CONTROL_ONE:   prdata_out[7:0] <= port_control_one;
					`OFS_CONTROL_TWO:   prdata_out[7:0] <= port_control_two;
					`OFS_CONTROL_THREE: prdata_out[7:0] <= port_control_three;
					`OFS_ADDRESS_MASK:  prdata_out[7:0] <= address_mask;
					`OFS_PORT_STATUS: begin
						prdata_out[`BIT_STOP_SEEN]  <= stop_seen;
						prdata_out[`BIT_START_SEEN] <= start_seen;
						prdata_out[`BIT_SHIFT_BUSY] <= state == i2c_collision_pkg::ST_SHIFT;
					end
					`OFS_COLLISION: begin
						prdata_out[`BIT_COLLISION]   <= collision_flag;
						prdata_out[`BIT_COLL_IRQ_EN] <= collision_irq_enable;
						prdata_out[`BIT_EVENT_FLAG]  <= port_event_flag;
					end
					default: prdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end

	// software registers and the byte shift; buffer write only lands while idle
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			baud_reload_value    <= `RST_BAUD_RELOAD;
			serial_shift_buffer  <= `RST_BYTE;
			port_control_one     <= `RST_BYTE;
			port_control_three   <= `RST_BYTE;
			address_mask         <= `RST_BYTE;
			collision_irq_enable <= 1'b0;
		end else begin
			if (wr && paddr_in == `OFS_BAUD_RELOAD)
				baud_reload_value <= pwdata_in[7:0];
			if (buf_write)
				serial_shift_buffer <= pwdata_in[7:0];
			else if (state == i2c_collision_pkg::ST_SHIFT && baud_expire && !scl_oe_n)
				serial_shift_buffer <= {serial_shift_buffer[6:0], sda_in};
			if (wr && paddr_in == `OFS_CONTROL_ONE)
				port_control_one <= pwdata_in[7:0];
			if (wr && paddr_in == `OFS_CONTROL_THREE)
				port_control_three <= pwdata_in[7:0];
			if (wr && paddr_in == `OFS_ADDRESS_MASK)
				address_mask <= pwdata_in[7:0];
			if (wr && paddr_in == `OFS_COLLISION)
				collision_irq_enable <= pwdata_in[`BIT_COLL_IRQ_EN];
		end
	end

	// condition requests: software sets while idle, hardware clears on finish or abort
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			port_control_two <= `RST_BYTE;
		end else if (set_coll || done) begin
			port_control_two[`BIT_STOP_REQ:`BIT_START_REQ] <= 3'h0;
		end else if (wr && paddr_in == `OFS_CONTROL_TWO && state == i2c_collision_pkg::ST_IDLE) begin
			port_control_two <= pwdata_in[7:0];
		end
	end

	// sticky flags: a hardware set in the same cycle wins over the clear
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			collision_flag  <= 1'b0;
			port_event_flag <= 1'b0;
		end else begin
			if (set_coll)
				collision_flag <= 1'b1;
			else if (wr && paddr_in == `OFS_COLLISION && coll_clear(pwdata_in, `BIT_COLLISION))
				collision_flag <= 1'b0;
			if (done)
				port_event_flag <= 1'b1;
			else if (wr && paddr_in == `OFS_COLLISION && coll_clear(pwdata_in, `BIT_EVENT_FLAG))
				port_event_flag <= 1'b0;
		end
	end

	// request line is a registered copy of flag and enable
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			collision_irq_out <= 1'b0;
		else
			collision_irq_out <= collision_flag && collision_irq_enable;
	end

	// one counter for both two-wire and peripheral-interface master clocking
	baud_counter #(
		.PRESCALE (`BAUD_PRESCALE)
	) u_baud (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n),
		.reload_in  (baud_reload_value),
		.load_in    (baud_load),
		.run_in     (baud_run),
		.expire_out (baud_expire)
	);

	// counter stops whenever the sequencer rests in idle
	assign baud_run = state != i2c_collision_pkg::ST_IDLE;

	// sequencer next state; outside ST_SHIFT, lines only change on a state step or a collision abort
	always_comb begin
		next_state    = state;
		next_sda_oe_n = sda_oe_n;
		next_scl_oe_n = scl_oe_n;
		baud_load     = 1'b0;
		set_coll      = 1'b0;
		done          = 1'b0;
		unique case (state)
			i2c_collision_pkg::ST_IDLE: begin
				if (port_control_one[`BIT_PORT_ENABLE] && !port_control_one[`BIT_SPI_MODE]) begin
					if (port_control_two[`BIT_START_REQ]) begin
						if (!sda_in || !scl_in) begin
							set_coll = 1'b1;
						end else begin
							baud_load  = 1'b1;
							next_state = i2c_collision_pkg::ST_START_WAIT;
						end
					end else if (port_control_two[`BIT_RESTART_REQ]) begin
						next_sda_oe_n = 1'b1;
						next_state    = i2c_collision_pkg::ST_RS_FLOAT;
					end else if (port_control_two[`BIT_STOP_REQ]) begin
						next_sda_oe_n = 1'b0;
						next_state    = i2c_collision_pkg::ST_STOP_LOW;
					end
				end
				if (buf_write && port_control_one[`BIT_PORT_ENABLE]) begin
					baud_load  = 1'b1;
					next_state = i2c_collision_pkg::ST_SHIFT;
				end
			end
			i2c_collision_pkg::ST_START_WAIT: begin
				if (!scl_in && sda_in) begin
					set_coll = 1'b1;
				end else if (!sda_in || baud_expire) begin
					baud_load     = 1'b1;
					next_sda_oe_n = 1'b0;
					next_state    = i2c_collision_pkg::ST_START_HOLD;
				end
			end
			i2c_collision_pkg::ST_START_HOLD: begin
				if (baud_expire) begin
					next_scl_oe_n = 1'b0;
					done          = 1'b1;
					next_state    = i2c_collision_pkg::ST_IDLE;
				end
			end
			i2c_collision_pkg::ST_RS_FLOAT: begin
				if (sda_in) begin
					baud_load  = 1'b1;
					next_state = i2c_collision_pkg::ST_RS_COUNT;
				end
			end
			i2c_collision_pkg::ST_RS_COUNT: begin
				if (baud_expire) begin
					next_scl_oe_n = 1'b1;
					next_state    = i2c_collision_pkg::ST_RS_CLKHI;
				end
			end
			i2c_collision_pkg::ST_RS_CLKHI: begin
				if (scl_in && !sda_in) begin
					set_coll = 1'b1;
				end else if (scl_in) begin
					baud_load  = 1'b1;
					next_state = i2c_collision_pkg::ST_RS_CHECK;
				end
			end
			i2c_collision_pkg::ST_RS_CHECK: begin
				if (!scl_in && sda_in) begin
					set_coll = 1'b1;
				end else if (baud_expire) begin
					baud_load     = 1'b1;
					next_sda_oe_n = 1'b0;
					next_state    = i2c_collision_pkg::ST_RS_HOLD;
				end
			end
			i2c_collision_pkg::ST_RS_HOLD: begin
				if (baud_expire) begin
					next_scl_oe_n = 1'b0;
					done          = 1'b1;
					next_state    = i2c_collision_pkg::ST_IDLE;
				end
			end
			i2c_collision_pkg::ST_STOP_LOW: begin
				if (!sda_in) begin
					next_scl_oe_n = 1'b1;
					next_state    = i2c_collision_pkg::ST_STOP_CLKHI;
				end
			end
			i2c_collision_pkg::ST_STOP_CLKHI: begin
				if (scl_in) begin
					baud_load  = 1'b1;
					next_state = i2c_collision_pkg::ST_STOP_COUNT;
				end
			end
			i2c_collision_pkg::ST_STOP_COUNT: begin
				if (!scl_in) begin
					set_coll = 1'b1;
				end else if (baud_expire) begin
					next_sda_oe_n = 1'b1;
					baud_load     = 1'b1;
					next_state    = i2c_collision_pkg::ST_STOP_CHECK;
				end
			end
			i2c_collision_pkg::ST_STOP_CHECK: begin
				if (baud_expire && !sda_in) begin
					set_coll = 1'b1;
				end else if (baud_expire) begin
					done       = 1'b1;
					next_state = i2c_collision_pkg::ST_IDLE;
				end
			end
			i2c_collision_pkg::ST_SHIFT: begin
				// each expiry is a half period; data changes on the expiry that releases the clock
				if (baud_expire) begin
					next_scl_oe_n = !scl_oe_n;
					if (!scl_oe_n)
						next_sda_oe_n = serial_shift_buffer[6];
					if (halves == `SHIFT_HALVES - 5'h1) begin
						done       = 1'b1;
						next_state = i2c_collision_pkg::ST_IDLE;
					end
				end
			end
		endcase
		// a collision aborts any condition and lets both lines float
		if (set_coll) begin
			next_state    = i2c_collision_pkg::ST_IDLE;
			next_sda_oe_n = 1'b1;
			next_scl_oe_n = 1'b1;
		end
		if (buf_write && port_control_one[`BIT_PORT_ENABLE] && next_state == i2c_collision_pkg::ST_SHIFT)
			next_sda_oe_n = pwdata_in[7];
	end

	// sequencer state and line drives; both lines hold their level in idle unless a collision abort floats them
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state    <= i2c_collision_pkg::ST_IDLE;
			sda_oe_n <= 1'b1;
			scl_oe_n <= 1'b1;
		end else begin
			state    <= next_state;
			sda_oe_n <= next_sda_oe_n;
			scl_oe_n <= next_scl_oe_n;
		end
	end

	// half period count of a byte sequence
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			halves <= 5'h00;
		else if (state != i2c_collision_pkg::ST_SHIFT)
			halves <= 5'h00;
		else if (baud_expire)
			halves <= halves + 5'h01;
	end

	// start and stop last completed by this master, for free-bus decisions by software
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			start_seen <= 1'b0;
			stop_seen  <= 1'b0;
		end else if (done && state != i2c_collision_pkg::ST_STOP_CHECK && state != i2c_collision_pkg::ST_SHIFT) begin
			start_seen <= 1'b1;
			stop_seen  <= 1'b0;
		end else if (done && state == i2c_collision_pkg::ST_STOP_CHECK) begin
			start_seen <= 1'b0;
			stop_seen  <= 1'b1;
		end
	end

	// open-drain pins only ever pull low
	assign sda_out      = 1'b0;
	assign scl_out      = 1'b0;
	assign sda_oe_n_out = sda_oe_n;
	assign scl_oe_n_out = scl_oe_n;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n);

	sequence seq_aborted;
		##1 (collision_flag && state == i2c_collision_pkg::ST_IDLE && sda_oe_n && scl_oe_n);
	endsequence

	a_start_busy_abort: assert property ((state == i2c_collision_pkg::ST_IDLE) && port_control_two[`BIT_START_REQ]
		&& port_control_one[`BIT_PORT_ENABLE] && !port_control_one[`BIT_SPI_MODE] && !buf_write
		&& (!sda_in || !scl_in) |-> seq_aborted) else $error("start on busy bus not aborted");
	a_start_clock_low: assert property ((state == i2c_collision_pkg::ST_START_WAIT) && !scl_in && sda_in
		|-> seq_aborted) else $error("clock low during start not flagged");
	a_start_early_drive: assert property ((state == i2c_collision_pkg::ST_START_WAIT) && !sda_in && scl_in
		|=> (state == i2c_collision_pkg::ST_START_HOLD) && !sda_oe_n && !$rose(collision_flag))
		else $error("early data drive missed");
	a_hold_ignores_clk: assert property ((state == i2c_collision_pkg::ST_START_HOLD) && !baud_expire
		|=> (state == i2c_collision_pkg::ST_START_HOLD) && !scl_oe_n == 1'b0 && !$rose(collision_flag))
		else $error("collision flagged in start hold");
	a_restart_data_low: assert property ((state == i2c_collision_pkg::ST_RS_CLKHI) && scl_in && !sda_in
		|-> seq_aborted) else $error("restart data low not flagged");
	a_restart_clk_fall: assert property ((state == i2c_collision_pkg::ST_RS_CHECK) && !scl_in && sda_in
		|-> seq_aborted) else $error("restart clock fall not flagged");
	a_restart_finish: assert property ((state == i2c_collision_pkg::ST_RS_HOLD) && baud_expire
		|=> !scl_oe_n && !sda_oe_n && port_event_flag) else $error("restart did not complete");
	a_stop_data_low: assert property ((state == i2c_collision_pkg::ST_STOP_CHECK) && baud_expire && !sda_in
		|-> seq_aborted) else $error("stop data low not flagged");
	a_stop_clk_low: assert property ((state == i2c_collision_pkg::ST_STOP_COUNT) && !scl_in
		|-> seq_aborted) else $error("stop clock low not flagged");
	a_abort_clears_req: assert property (set_coll |=> port_control_two[2:0] == 3'h0)
		else $error("request bits left set after collision");
	a_flag_sticky: assert property (collision_flag && !(wr && paddr_in == `OFS_COLLISION) |=> collision_flag)
		else $error("collision flag dropped");
	a_irq_follows: assert property (collision_flag && collision_irq_enable |=> collision_irq_out)
		else $error("collision request missing");

endmodule

// ===== i2c_bus_partner.sv
/*
 * far side of the two-wire bus: pull-up resistors on both lines and a
 * second master that can hold either line low when the bench asks it to.
 * assumes the device drives open-drain enables, low meaning pull low.
 */
`timescale 1ns/1ps

module i2c_bus_partner (
	input  wire logic sda_oe_n_in,
	input  wire logic scl_oe_n_in,
	input  wire logic hold_sda_low_in,
	input  wire logic hold_scl_low_in,
	output logic      sda_line_out,
	output logic      scl_line_out
);
	// wired-and with pull-up: a released line reads high, never the last driven value
	assign sda_line_out = ~(~sda_oe_n_in | hold_sda_low_in);
	// holding clock low also models a slow slave stretching the clock
	assign scl_line_out = ~(~scl_oe_n_in | hold_scl_low_in);
endmodule

// ===== test_i2c_master_collision_brg.sv
/*
 * self-checking bench: apb register tasks, start, restart and stop with
 * and without a second master fighting on the lines, and a byte shift.
 * assumes the bus partner model and the constants header are compiled.
 */
`timescale 1ns/1ps
`include "i2c_collision_consts.svh"

module test_i2c_master_collision_brg;
	localparam int T = 2 * (3 + 1); // half period for reload value 3
	logic        clk_in = 1'b0, resetn_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic        pready, pslverr, sda_oe_n, scl_oe_n, irq, sda_line, scl_line, e;
	logic        hold_sda = 1'b0, hold_scl = 1'b0;
	int          err_count = 0, checked = 0, n, g;

	always #2.5 clk_in = ~clk_in;

	i2c_master_collision_brg u_i2c_master_collision_brg (.clk_in(clk_in), .resetn_in(resetn_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .sda_in(sda_line), .sda_out(),
		.sda_oe_n_out(sda_oe_n), .scl_in(scl_line), .scl_out(), .scl_oe_n_out(scl_oe_n),
		.collision_irq_out(irq));
	i2c_bus_partner u_i2c_bus_partner (.sda_oe_n_in(sda_oe_n), .scl_oe_n_in(scl_oe_n),
		.hold_sda_low_in(hold_sda), .hold_scl_low_in(hold_scl), .sda_line_out(sda_line),
		.scl_line_out(scl_line));

	task summarize;
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen at a rising edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic er);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_in);
		penable <= 1'b1;
		do begin
			@(posedge clk_in);
			k++;
		end while (pready !== 1'b1 && k < 40);
		if (k >= 40) begin
			err_count++;
			summarize;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_in);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, r, e);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, r, e);
		chk(r & m, exp);
	endtask

	task idle(input int c);
		repeat (c) @(posedge clk_in);
	endtask

	// bounded wait for one line enable to reach a level; counts the cycles taken
	task waitfor(input logic sel, input logic v, output int k);
		k = 0;
		while (((sel ? scl_oe_n : sda_oe_n) !== v) && k < 400) begin
			@(posedge clk_in);
			k++;
		end
		if (k >= 400) begin
			err_count++;
			summarize;
		end
	endtask

	// after a fight: flag up, request dropped, lines released, irq raised, then cleared
	task coll_check;
		rd(`OFS_COLLISION, 32'h1, 32'h1);
		rd(`OFS_CONTROL_TWO, 32'hFF, 32'h0);
		chk({sda_oe_n, scl_oe_n}, 32'h3);
		chk(irq, 32'h1);
		wr(`OFS_COLLISION, 32'h7);
		idle(2);
		chk(irq, 32'h0);
	endtask

	task start_ok;
		wr(`OFS_CONTROL_TWO, 32'h1);
		waitfor(1'b0, 1'b0, n);
		waitfor(1'b1, 1'b0, g);
		chk(g >= T && g <= T + 2, 32'h1);
		rd(`OFS_CONTROL_TWO, 32'hFF, 32'h0);
	endtask

	task stop_ok;
		wr(`OFS_CONTROL_TWO, 32'h4);
		waitfor(1'b1, 1'b1, n);
		waitfor(1'b0, 1'b1, n);
		idle(T + 4);
		rd(`OFS_PORT_STATUS, 32'h10, 32'h10);
		rd(`OFS_COLLISION, 32'h1, 32'h0);
		chk({sda_oe_n, scl_oe_n}, 32'h3);
	endtask

	initial begin
		repeat (12) @(posedge clk_in);
		resetn_in <= 1'b1;
		idle(3);
		for (int i = 0; i < 8; i++)
			rd(8'(i * 4), 32'hFF, i == 0 ? 32'h13 : 32'h0);
		apb(1'b0, 8'h20, 32'h0, r, e);
		chk(e, 32'h1);
		chk(r, 32'h0);
		wr(`OFS_BAUD_RELOAD, 32'h3);
		rd(`OFS_BAUD_RELOAD, 32'hFF, 32'h3);
		wr(`OFS_CONTROL_ONE, 32'h20);
		wr(`OFS_COLLISION, 32'h2);
		$display("registers done");
		start_ok;
		stop_ok;
		$display("start and stop done");
		// data pulled low mid-count makes the start drive data early, not collide
		wr(`OFS_CONTROL_TWO, 32'h1);
		idle(2);
		hold_sda <= 1'b1;
		waitfor(1'b0, 1'b0, n);
		chk(n < T, 32'h1);
		hold_sda <= 1'b0;
		waitfor(1'b1, 1'b0, g);
		rd(`OFS_COLLISION, 32'h1, 32'h0);
		stop_ok;
		$display("early start done");
		hold_sda <= 1'b1;
		idle(2);
		wr(`OFS_CONTROL_TWO, 32'h1);
		idle(4);
		coll_check;
		hold_sda <= 1'b0;
		wr(`OFS_CONTROL_TWO, 32'h1);
		hold_scl <= 1'b1;
		idle(T + 4);
		coll_check;
		hold_scl <= 1'b0;
		idle(2);
		$display("start fights done");
		start_ok;
		wr(`OFS_CONTROL_TWO, 32'h2);
		waitfor(1'b0, 1'b1, n);
		idle(3);
		hold_sda <= 1'b1;
		idle(3 * T);
		coll_check;
		hold_sda <= 1'b0;
		start_ok;
		wr(`OFS_CONTROL_TWO, 32'h2);
		waitfor(1'b0, 1'b1, n);
		waitfor(1'b1, 1'b1, n);
		waitfor(1'b0, 1'b0, n);
		waitfor(1'b1, 1'b0, g);
		chk(g >= T && g <= T + 2, 32'h1);
		rd(`OFS_CONTROL_TWO, 32'hFF, 32'h0);
		rd(`OFS_COLLISION, 32'h1, 32'h0);
		stop_ok;
		$display("restart done");
		start_ok;
		hold_sda <= 1'b1;
		wr(`OFS_CONTROL_TWO, 32'h4);
		idle(3 * T + 6);
		coll_check;
		hold_sda <= 1'b0;
		start_ok;
		wr(`OFS_CONTROL_TWO, 32'h4);
		waitfor(1'b1, 1'b1, n);
		idle(3);
		hold_scl <= 1'b1;
		idle(2 * T + 4);
		coll_check;
		hold_scl <= 1'b0;
		$display("stop fights done");
		wr(`OFS_SHIFT_BUFFER, 32'hA5);
		rd(`OFS_PORT_STATUS, 32'h1, 32'h1);
		idle(16 * T + 20);
		rd(`OFS_PORT_STATUS, 32'h1, 32'h0);
		rd(`OFS_SHIFT_BUFFER, 32'hFF, 32'hA5);
		$display("shift done");
		summarize;
	end
endmodule
